// file: hw/bod_pkg.sv
/*
 * Shared constants for the branch and operand decode unit: opcodes,
 * status word layout, reset values and the sequencer state type.
 * Assumes nothing of its surroundings beyond a SystemVerilog compiler.
 */
package bod_pkg;

    // Whole-byte opcodes of the control-flow instructions and the pointer load
    localparam logic [7:0] OP_LONG_JUMP    = 8'h02; // Long jump
    localparam logic [7:0] OP_LONG_SUBROUTINE_CALL   = 8'h12; // Long subroutine call
    localparam logic [7:0] OP_RET     = 8'h22; // Subroutine return
    localparam logic [7:0] OP_INTERRUPT_RETURN    = 8'h32; // Interrupt return
    localparam logic [7:0] OP_JZ      = 8'h60; // Branch if acc zero
    localparam logic [7:0] OP_JNZ     = 8'h70; // Branch if acc nonzero
    localparam logic [7:0] OP_JMPI    = 8'h73; // Jump to acc + pointer
    localparam logic [7:0] OP_SHORT_RELATIVE_JUMP    = 8'h80; // Short relative jump
    localparam logic [7:0] OP_MOVDP   = 8'h90; // Load pointer, 16-bit
    localparam logic [7:0] OP_CJ_AI   = 8'hb4; // Compare acc, immediate
    localparam logic [7:0] OP_CJ_AD   = 8'hb5; // Compare acc, direct
    localparam logic [7:0] OP_DJ_DIR  = 8'hd5; // Decrement direct, branch

    // Partial opcode fields (page forms carry target bits in 7:5)
    localparam logic [4:0] OP_PAGE_ABSOLUTE_JUMP_LO  = 5'h01; // Page jump, bits 4:0
    localparam logic [4:0] OP_PAGE_ABSOLUTE_CALL_LO = 5'h11; // Page call, bits 4:0
    localparam logic [6:0] OP_CJ_IND   = 7'h5b; // Compare indirect, 7:1
    localparam logic [4:0] OP_CJ_REG   = 5'h17; // Compare register, 7:3
    localparam logic [4:0] OP_DJ_REG   = 5'h1b; // Decrement register, 7:3

    // Flag-updating arithmetic groups (high nibble), operand forms >= 4
    localparam logic [3:0] NIB_ADD    = 4'h2;
    localparam logic [3:0] NIB_ADDC   = 4'h3;
    localparam logic [3:0] NIB_SUBB   = 4'h9;
    localparam logic [3:0] NIB_OPND   = 4'h4; // First operand form
    localparam logic [2:0] NIB_TWO_B  = 3'h2; // Forms 4 and 5: two bytes

    // Status word location and bit positions
    localparam logic [7:0] PSW_ADDR   = 8'hd0;
    localparam int         PSW_CY     = 7;
    localparam int         PSW_AC     = 6;
    localparam int         PSW_RS1    = 4;
    localparam int         PSW_RS0    = 3;
    localparam int         PSW_OV     = 2;

    // Reset values
    localparam logic [7:0]  PSW_RST   = 8'h00;
    localparam logic [7:0]  SP_RST    = 8'h07;
    localparam logic [15:0] PC_RST    = 16'h0000;

    // Instruction sequencer, Gray along fetch -> execute -> stack
    typedef enum logic [2:0] {
        S_OP   = 3'b000, // Opcode fetch
        S_B2   = 3'b001, // Second byte fetch
        S_B3   = 3'b011, // Third byte fetch
        S_IND  = 3'b010, // Indirect pointer read
        S_EXEC = 3'b110, // Execute
        S_ST1  = 3'b111, // First stack / write-back step
        S_ST2  = 3'b101  // Second stack step
    } bod_state_type;

endpackage

// file: hw/bod_add16.sv
/*
 * Sixteen-bit base plus eight-bit offset adder, signed or unsigned.
 * Assumes a purely combinational use inside the decode unit.
 */
`timescale 1ns/1ps

module bod_add16 #(
    parameter bit SIGNED_OFF = 1'b1 // Sign-extend the offset byte
) (
    input  wire logic [15:0] BASE,  // Base address
    input  wire logic [7:0]  OFF,   // Offset byte
    output wire logic [15:0] SUM    // Wrapped 16-bit sum
);

    // Extension bits: copies of the sign, or zero for unsigned use
    wire logic [7:0] ext_bits = SIGNED_OFF ? {8{OFF[7]}} : 8'h00;

    // Wraps modulo 64K like the program counter itself
    assign SUM = BASE + {ext_bits, OFF};

endmodule

// file: hw/bod_core.sv
/*
 * Control-flow sequencer of an 8-bit CPU core: jumps, calls, returns,
 * conditional branches, operand address decode and the status word.
 * Assumes program memory and the data/SFR space answer combinationally
 * in the same cycle, all on CLK_SYS; the datapath supplies the
 * accumulator, pointer and arithmetic flag results.
 */
`timescale 1ns/1ps

// Summary of operation
// - Short jump: opcode plus signed offset
// - Long jump: two bytes give full address
// - Page jump swaps low eleven PC bits
// - Indexed jump loads pointer plus accumulator
// - Long call takes full sixteen-bit target
// - Page call stays in following 2K block
// - Call pushes return low first, SP+2
// - Return resumes after the calling instruction
// - Interrupt return also signals service done
// - Conditional branches use relative offsets only
// - Offset is signed, added only if taken
// - Zero branches test accumulator directly
// - Decrement operand, branch when result nonzero
// - Compare two bytes, branch when different
// - Unsigned compare sets carry when less
// - Status word writes change the flags
// - Arithmetic, compare and status word writes change flags
// - Register operand uses selected bank
// - Direct below 128 RAM, else SFR
// - Indirect uses R0 or R1 pointer
// - Immediate byte; pointer load takes sixteen
module bod_core
    import bod_pkg::*;
(
    input  wire logic        CLK_SYS,     // Core clock, 125 MHz
    input  wire logic        RST,         // Async reset, active high
    output wire logic [15:0] PM_ADDR,     // Program fetch address
    input  wire logic [7:0]  PM_DATA,     // Program byte at PM_ADDR
    input  wire logic [7:0]  ACC,         // Accumulator contents
    input  wire logic [15:0] DATA_POINTER_REGISTER,        // Data pointer register
    output wire logic [7:0]  DATA_ADDR,   // Data space address
    output wire logic        DATA_SFR,    // Address is in SFR space
    input  wire logic [7:0]  DATA_RDATA,  // Read data at DATA_ADDR
    output wire logic        DATA_WE,     // Write strobe
    output wire logic [7:0]  DATA_WDATA,  // Write data
    input  wire logic        ALU_CY,      // Arithmetic carry out
    input  wire logic        ALU_OV,      // Arithmetic overflow
    input  wire logic        ALU_AC,      // Arithmetic half carry
    input  wire logic        SFR_WE,      // Datapath SFR byte write
    input  wire logic [7:0]  SFR_WADDR,   // Its SFR address
    input  wire logic [7:0]  SFR_WDATA,   // Its data
    input  wire logic        BIT_WE,      // Datapath bit write
    input  wire logic [7:0]  BIT_WADDR,   // Its bit address
    input  wire logic        BIT_WDATA,   // Its bit value
    input  wire logic        IRQ_IN_SERVICE, // Interrupt in progress
    output wire logic        IRQ_DONE,    // Service finished pulse
    output wire logic        DATA_POINTER_REGISTER_WE,     // Pointer load pulse
    output wire logic [15:0] DATA_POINTER_REGISTER_WDATA,  // Pointer load value
    output wire logic [7:0]  PROGRAM_STATUS_WORD,         // Status word
    output wire logic [7:0]  SP           // Stack pointer
);

    // Sequencer and architectural state
    bod_state_type state_q, state_d;      // Sequencer state
    logic [15:0]   pc_q, pc_d;            // Program counter
    logic [7:0]    sp_q, sp_d;            // Stack pointer
    logic [7:0]    psw_q, psw_d;          // Status word
    logic [7:0]    op_q, op_d;            // Latched opcode
    logic [7:0]    b2_q, b2_d;            // Second instruction byte
    logic [7:0]    b3_q, b3_d;            // Third instruction byte
    logic [7:0]    ind_q, ind_d;          // Indirect pointer value
    logic [7:0]    wd_q, wd_d;            // Write data / pop scratch
    logic          irq_done_q, irq_done_d; // Service done pulse
    logic          dpw_q, dpw_d;          // Pointer load pulse
    logic [15:0]   dpd_q, dpd_d;          // Pointer load value

    // Opcode under decode: the fetched byte while fetching, else latched
    wire logic [7:0] cur_op = (state_q == S_OP) ? PM_DATA : op_q;

    // Instruction class decode
    wire logic is_page_absolute_jump  = cur_op[4:0] == OP_PAGE_ABSOLUTE_JUMP_LO;
    wire logic is_page_absolute_call = cur_op[4:0] == OP_PAGE_ABSOLUTE_CALL_LO;
    wire logic is_long_jump  = cur_op == OP_LONG_JUMP;
    wire logic is_long_subroutine_call = cur_op == OP_LONG_SUBROUTINE_CALL;
    wire logic is_interrupt_return  = cur_op == OP_INTERRUPT_RETURN;
    wire logic is_ret   = (cur_op == OP_RET) || is_interrupt_return;
    wire logic is_jz    = cur_op == OP_JZ;
    wire logic is_jnz   = cur_op == OP_JNZ;
    wire logic is_jmpi  = cur_op == OP_JMPI;
    wire logic is_short_relative_jump  = cur_op == OP_SHORT_RELATIVE_JUMP;
    wire logic is_movdp = cur_op == OP_MOVDP;
    wire logic is_cj_ai = cur_op == OP_CJ_AI;
    wire logic is_cj_ad = cur_op == OP_CJ_AD;
    wire logic is_cj_in = cur_op[7:1] == OP_CJ_IND;
    wire logic is_cj_rg = cur_op[7:3] == OP_CJ_REG;
    wire logic is_dj_d  = cur_op == OP_DJ_DIR;
    wire logic is_dj_rg = cur_op[7:3] == OP_DJ_REG;
    wire logic is_compare_and_branch  = is_cj_ai || is_cj_ad || is_cj_in || is_cj_rg;
    wire logic is_decrement_and_branch  = is_dj_d || is_dj_rg;
    wire logic is_call  = is_page_absolute_call || is_long_subroutine_call;

    // Of the arithmetic groups, only add, add-with-carry and subtract move the flags
    wire logic arith_grp = (cur_op[7:4] == NIB_ADD)
                        || (cur_op[7:4] == NIB_ADDC)
                        || (cur_op[7:4] == NIB_SUBB);
    wire logic is_arith  = arith_grp && (cur_op[3:0] >= NIB_OPND);

    // Instruction length; other opcodes are fetched as one byte
    wire logic len3 = is_long_jump || is_long_subroutine_call || is_compare_and_branch || is_dj_d
                   || is_movdp;
    wire logic len2 = is_page_absolute_jump || is_page_absolute_call || is_short_relative_jump || is_jz
                   || is_jnz || is_dj_rg
                   || (is_arith && cur_op[3:1] == NIB_TWO_B);

    // Register operand: bank bits from the status word, index from op
    wire logic [7:0] reg_addr = {3'b000, psw_q[PSW_RS1], psw_q[PSW_RS0],
                                 cur_op[2:0]};
    // Pointer register R0 or R1 of the active bank
    wire logic [7:0] ptr_addr = {3'b000, psw_q[PSW_RS1], psw_q[PSW_RS0],
                                 2'b00, cur_op[0]};

    // Operand location for compare and decrement forms
    wire logic       opnd_dir  = is_cj_ad || is_dj_d;
    wire logic [7:0] opnd_addr = opnd_dir ? b2_q
                               : is_cj_in ? ind_q : reg_addr;
    // Direct addresses with the top bit set reach the SFRs
    wire logic       opnd_sfr  = opnd_dir && b2_q[7];

    // Stack slot addresses
    wire logic [7:0] sp_inc1 = sp_q + 8'h01;
    wire logic [7:0] sp_inc2 = sp_q + 8'h02;
    wire logic [7:0] sp_dec1 = sp_q - 8'h01;
    wire logic [7:0] sp_dec2 = sp_q - 8'h02;

    // Data space address selection per sequencer step
    wire logic stk_push1 = (state_q == S_ST1) && is_call;
    wire logic stk_pop1  = (state_q == S_ST1) && is_ret;
    wire logic decrement_and_branch_wb   = (state_q == S_ST1) && is_decrement_and_branch;
    wire logic exec_ret  = (state_q == S_EXEC) && is_ret;
    assign DATA_ADDR = (state_q == S_IND) ? ptr_addr
                     : exec_ret           ? sp_q
                     : stk_pop1           ? sp_dec1
                     : stk_push1          ? sp_inc1
                     : (state_q == S_ST2) ? sp_inc2
                     : opnd_addr;
    // Indirect and stack accesses always stay in RAM
    assign DATA_SFR  = (state_q == S_EXEC || decrement_and_branch_wb) && !is_ret
                     && opnd_sfr;
    assign DATA_WE   = stk_push1 || decrement_and_branch_wb || (state_q == S_ST2);
    assign DATA_WDATA = wd_q;

    // The status word lives here, so its own address reads locally
    wire logic       psw_hit = DATA_SFR && (DATA_ADDR == PSW_ADDR);
    wire logic [7:0] rd      = psw_hit ? psw_q : DATA_RDATA;

    // Compare operands: accumulator forms, else the addressed byte
    wire logic       acc_first  = is_cj_ai || is_cj_ad;
    wire logic [7:0] cmp_first  = acc_first ? ACC : rd;
    wire logic [7:0] cmp_second = is_cj_ad ? rd : b2_q;
    wire logic       cmp_ne     = cmp_first != cmp_second;
    wire logic       cmp_lt     = cmp_first < cmp_second;

    // Offset byte: third byte for three-byte branches
    wire logic [7:0] rel_off = (is_compare_and_branch || is_dj_d) ? b3_q : b2_q;

    // Relative target from the already-advanced program counter
    wire logic [15:0] rel_tgt;
    bod_add16 #(
        .SIGNED_OFF (1'b1)
    ) u_rel (
        .BASE (pc_q),
        .OFF  (rel_off),
        .SUM  (rel_tgt)
    );

    // Case-jump target: pointer plus unsigned accumulator
    wire logic [15:0] acc_tgt;
    bod_add16 #(
        .SIGNED_OFF (1'b0)
    ) u_acc (
        .BASE (DATA_POINTER_REGISTER),
        .OFF  (ACC),
        .SUM  (acc_tgt)
    );

    // Absolute targets; the page form keeps the upper five PC bits
    wire logic [15:0] page_tgt = {pc_q[15:11], op_q[7:5], b2_q};
    wire logic [15:0] long_tgt = {b2_q, b3_q};

    // Branch decision for single-step conditional forms
    wire logic acc_zero = ACC == 8'h00;
    wire logic exec_tk  = is_short_relative_jump || (is_jz && acc_zero)
                       || (is_jnz && !acc_zero)
                       || (is_compare_and_branch && cmp_ne);

    // Next-state and datapath steering
    always_comb begin
        state_d    = state_q;
        pc_d       = pc_q;
        sp_d       = sp_q;
        op_d       = op_q;
        b2_d       = b2_q;
        b3_d       = b3_q;
        ind_d      = ind_q;
        wd_d       = wd_q;
        irq_done_d = 1'b0;
        dpw_d      = 1'b0;
        dpd_d      = dpd_q;
        case (state_q)
            S_OP: begin
                // Latch opcode and step past it
                op_d = PM_DATA;
                pc_d = pc_q + 16'h0001;
                if (len2 || len3) begin
                    state_d = S_B2;
                end else begin
                    state_d = S_EXEC;
                end
            end
            S_B2: begin
                b2_d = PM_DATA;
                pc_d = pc_q + 16'h0001;
                if (len3) begin
                    state_d = S_B3;
                end else begin
                    state_d = S_EXEC;
                end
            end
            S_B3: begin
                b3_d = PM_DATA;
                pc_d = pc_q + 16'h0001;
                // Indirect compare needs its pointer first
                if (is_cj_in) begin
                    state_d = S_IND;
                end else begin
                    state_d = S_EXEC;
                end
            end
            S_IND: begin
                ind_d   = rd;
                state_d = S_EXEC;
            end
            S_EXEC: begin
                state_d = S_OP;
                if (is_page_absolute_jump) begin
                    pc_d = page_tgt;
                end else if (is_long_jump) begin
                    pc_d = long_tgt;
                end else if (is_jmpi) begin
                    pc_d = acc_tgt;
                end else if (exec_tk) begin
                    pc_d = rel_tgt;
                end else if (is_call) begin
                    // Return address is the advanced PC, low byte first
                    wd_d    = pc_q[7:0];
                    state_d = S_ST1;
                end else if (is_ret) begin
                    // High return byte sits on top of the stack
                    wd_d    = rd;
                    state_d = S_ST1;
                end else if (is_decrement_and_branch) begin
                    wd_d    = rd - 8'h01;
                    state_d = S_ST1;
                end else if (is_movdp) begin
                    dpw_d = 1'b1;
                    dpd_d = long_tgt;
                end
            end
            S_ST1: begin
                state_d = S_OP;
                if (is_call) begin
                    wd_d    = pc_q[15:8];
                    state_d = S_ST2;
                end else if (is_ret) begin
                    pc_d       = {wd_q, rd};
                    sp_d       = sp_dec2;
                    irq_done_d = is_interrupt_return && IRQ_IN_SERVICE;
                end else if (wd_q != 8'h00) begin
                    pc_d = rel_tgt;
                end
            end
            S_ST2: begin
                sp_d    = sp_inc2;
                pc_d    = is_long_subroutine_call ? long_tgt : page_tgt;
                state_d = S_OP;
            end
            default: begin
                state_d = S_OP;
            end
        endcase
    end

    // Flag updates: instructions first, software writes override
    always_comb begin
        psw_d = psw_q;
        if (state_q == S_EXEC && is_arith) begin
            psw_d[PSW_CY] = ALU_CY;
            psw_d[PSW_OV] = ALU_OV;
            psw_d[PSW_AC] = ALU_AC;
        end
        if (state_q == S_EXEC && is_compare_and_branch) begin
            psw_d[PSW_CY] = cmp_lt;
        end
        // A decrement aimed at the status word lands here, not in RAM
        if (decrement_and_branch_wb && psw_hit) begin
            psw_d = wd_q;
        end
        if (BIT_WE && BIT_WADDR[7:3] == PSW_ADDR[7:3]) begin
            psw_d[BIT_WADDR[2:0]] = BIT_WDATA;
        end
        if (SFR_WE && SFR_WADDR == PSW_ADDR) begin
            psw_d = SFR_WDATA;
        end
    end

    // Sequencer and program counter registers
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            state_q <= S_OP;
            pc_q    <= PC_RST;
            sp_q    <= SP_RST;
            psw_q   <= PSW_RST;
        end else begin
            state_q <= state_d;
            pc_q    <= pc_d;
            sp_q    <= sp_d;
            psw_q   <= psw_d;
        end
    end

    // Instruction bytes and scratch registers
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            op_q  <= 8'h00;
            b2_q  <= 8'h00;
            b3_q  <= 8'h00;
            ind_q <= 8'h00;
            wd_q  <= 8'h00;
        end else begin
            op_q  <= op_d;
            b2_q  <= b2_d;
            b3_q  <= b3_d;
            ind_q <= ind_d;
            wd_q  <= wd_d;
        end
    end

    // One-cycle output pulses and the pointer load value
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            irq_done_q <= 1'b0;
            dpw_q      <= 1'b0;
            dpd_q      <= 16'h0000;
        end else begin
            irq_done_q <= irq_done_d;
            dpw_q      <= dpw_d;
            dpd_q      <= dpd_d;
        end
    end

    assign PM_ADDR    = pc_q;
    assign IRQ_DONE   = irq_done_q;
    assign DATA_POINTER_REGISTER_WE    = dpw_q;
    assign DATA_POINTER_REGISTER_WDATA = dpd_q;
    assign PROGRAM_STATUS_WORD        = psw_q;
    assign SP         = sp_q;

    // Checks on the sequencer, all in the one clock domain
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);

    wire logic in_exec = state_q == S_EXEC;
    // Pop step of an interrupt return that owes the controller a pulse
    wire logic interrupt_return_pop = (state_q == S_ST1) && is_interrupt_return && IRQ_IN_SERVICE;

    a_short_rel: assert property (
        in_exec && is_short_relative_jump |=> pc_q == 16'($past(pc_q)
            + {{8{$past(b2_q[7])}}, $past(b2_q)}))
        else $error("short jump target wrong");

    a_long_tgt: assert property (
        in_exec && is_long_jump |=> pc_q == {$past(b2_q), $past(b3_q)})
        else $error("long jump target wrong");

    a_page_keep: assert property (
        in_exec && is_page_absolute_jump |=> pc_q[15:11] == $past(pc_q[15:11])
            && pc_q[7:0] == $past(b2_q))
        else $error("page jump changed upper bits");

    a_case_sum: assert property (
        in_exec && is_jmpi |=> pc_q == 16'($past(DATA_POINTER_REGISTER) + $past(ACC)))
        else $error("indexed jump sum wrong");

    // Call: low byte to SP+1, then high byte to SP+2, then SP moves
    sequence push_lo;
        DATA_WE && DATA_ADDR == 8'(sp_q + 8'h01);
    endsequence
    sequence push_hi;
        DATA_WE && DATA_ADDR == 8'(sp_q + 8'h02);
    endsequence
    a_call_push: assert property (
        in_exec && is_call |=> push_lo ##1 push_hi
            ##1 (sp_q == 8'($past(sp_q, 3) + 8'h02) && state_q == S_OP))
        else $error("call push sequence wrong");

    a_ret_pop: assert property (
        in_exec && is_ret |=> state_q == S_ST1
            ##1 sp_q == 8'($past(sp_q, 2) - 8'h02))
        else $error("return pop sequence wrong");

    a_zero_test: assert property (
        in_exec && is_jz && ACC != 8'h00 |=> pc_q == $past(pc_q))
        else $error("zero branch taken on nonzero acc");

    a_cmp_carry: assert property (
        in_exec && is_compare_and_branch && !SFR_WE && !BIT_WE
            |=> psw_q[PSW_CY] == $past(cmp_lt))
        else $error("compare carry wrong");

    a_interrupt_return_done: assert property (
        IRQ_DONE |-> $past(interrupt_return_pop))
        else $error("service done without interrupt return");

    a_interrupt_return_pulse: assert property (
        interrupt_return_pop |=> IRQ_DONE)
        else $error("interrupt return gave no service done");

    a_psw_write: assert property (
        SFR_WE && SFR_WADDR == PSW_ADDR |=> psw_q == $past(SFR_WDATA))
        else $error("status word write lost");

endmodule

// file: tb/bod_prog_mem.sv
/*
 * Far-side model: program ROM and internal data RAM.
 * Assumes fetch and read answer in the same cycle, writes on CLK_SYS.
 */
`timescale 1ns/1ps
module bod_prog_mem (
    input  wire logic        clk_sys,
    input  wire logic [15:0] pm_addr,
    output wire logic [7:0]  pm_data,
    input  wire logic [7:0]  data_addr,
    output wire logic [7:0]  data_rdata,
    input  wire logic        data_we,
    input  wire logic [7:0]  data_wdata
);
    logic [7:0] rom [0:65535]; // Program bytes, filled by the bench
    logic [7:0] ram [0:255];   // Data bytes
    // Empty ROM reads as no-op so a stray jump does not run on unknowns
    initial begin
        for (int i = 0; i < 65536; i++) rom[i] = 8'h00;
        for (int i = 0; i < 256; i++) ram[i] = 8'h00;
    end
    // Same-cycle answers, as the core expects
    assign pm_data    = rom[pm_addr];
    assign data_rdata = ram[data_addr];
    // Writes land at the strobe edge
    always @(posedge clk_sys) begin
        if (data_we) begin
            ram[data_addr] <= data_wdata;
        end
    end
endmodule

// file: tb/tb_cpu_branch_and_operand_decode.sv
/*
 * Bench for the control-flow core: runs a short program and checks
 * stack writes, final stack pointer, flags and the service-done pulse.
 * Assumes the ROM/RAM model answers combinationally.
 */
`timescale 1ns/1ps
module tb_cpu_branch_and_operand_decode;
    import bod_pkg::*;
    logic        CLK_SYS = 0, RST = 1, IRQ_IN_SERVICE = 0;
    logic        SFR_WE = 0, BIT_WE = 0, BIT_WDATA = 0;
    logic        ALU_CY = 0, ALU_OV = 0, ALU_AC = 0;
    logic [7:0]  ACC = 0, SFR_WADDR = 0, SFR_WDATA = 0, BIT_WADDR = 0;
    logic [15:0] DATA_POINTER_REGISTER = 0;
    wire  [15:0] PM_ADDR, DATA_POINTER_REGISTER_WDATA;
    wire  [7:0]  PM_DATA, DATA_ADDR, DATA_RDATA, DATA_WDATA, PROGRAM_STATUS_WORD, SP;
    wire         DATA_SFR, DATA_WE, IRQ_DONE, DATA_POINTER_REGISTER_WE;
    int          err_count = 0, samples_checked = 0, irq_seen = 0;
    int          dp_seen = 0; // Pointer load pulses seen
    logic [15:0] q [$];   // Expected stack/data writes {addr, data}
    logic [15:0] back_addr; // Return address pushed by the probe call
    // Clock, 8 ns period
    initial forever #4 CLK_SYS = ~CLK_SYS;
    bod_core dut_u (.CLK_SYS(CLK_SYS), .RST(RST), .PM_ADDR(PM_ADDR),
        .PM_DATA(PM_DATA), .ACC(ACC), .DATA_POINTER_REGISTER(DATA_POINTER_REGISTER), .DATA_ADDR(DATA_ADDR),
        .DATA_SFR(DATA_SFR), .DATA_RDATA(DATA_RDATA), .DATA_WE(DATA_WE),
        .DATA_WDATA(DATA_WDATA), .ALU_CY(ALU_CY), .ALU_OV(ALU_OV),
        .ALU_AC(ALU_AC), .SFR_WE(SFR_WE), .SFR_WADDR(SFR_WADDR),
        .SFR_WDATA(SFR_WDATA), .BIT_WE(BIT_WE), .BIT_WADDR(BIT_WADDR),
        .BIT_WDATA(BIT_WDATA), .IRQ_IN_SERVICE(IRQ_IN_SERVICE),
        .IRQ_DONE(IRQ_DONE), .DATA_POINTER_REGISTER_WE(DATA_POINTER_REGISTER_WE), .DATA_POINTER_REGISTER_WDATA(DATA_POINTER_REGISTER_WDATA),
        .PROGRAM_STATUS_WORD(PROGRAM_STATUS_WORD), .SP(SP));
    bod_prog_mem mem_u (.clk_sys(CLK_SYS), .pm_addr(PM_ADDR),
        .pm_data(PM_DATA), .data_addr(DATA_ADDR), .data_rdata(DATA_RDATA),
        .data_we(DATA_WE), .data_wdata(DATA_WDATA));
    task chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task close_out;
        $display("errors=%0d checks=%0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Three program bytes from one address
    task put(input logic [15:0] ad, input logic [7:0] b0, b1, b2);
        mem_u.rom[ad] = b0;
        mem_u.rom[ad + 16'h1] = b1;
        mem_u.rom[ad + 16'h2] = b2;
    endtask
    // Watcher: a strobe stands one cycle, so look mid-cycle
    always @(negedge CLK_SYS) begin
        if (!RST && DATA_WE === 1'b1) begin
            chk({15'h0, DATA_SFR}, 16'h0);
            if (q.size() == 0) chk({DATA_ADDR, DATA_WDATA}, 16'hxxxx);
            else chk({DATA_ADDR, DATA_WDATA}, q.pop_front());
        end
        if (IRQ_DONE === 1'b1) irq_seen++;
        if (DATA_POINTER_REGISTER_WE === 1'b1) begin
            dp_seen++;
            chk(DATA_POINTER_REGISTER_WDATA, 16'h1234);
        end
    end
    // Watchdog, well past the program's few dozen cycles
    initial begin
        #20000;
        err_count++;
        close_out;
    end
    // Main sequence
    initial begin
        void'($urandom(77));
        ACC = 8'($urandom_range(254, 1));   // Nonzero, below 8'hff
        DATA_POINTER_REGISTER = 16'h0500;
        back_addr = 16'h0503 + {8'h00, ACC};
        {ALU_CY, ALU_OV, ALU_AC} = 3'($urandom); // Flags the add takes
        IRQ_IN_SERVICE = 1;
        #1;
        mem_u.ram[8'h30] = 8'h01;
        put(16'h0000, 8'h12, 8'h03, 8'h45);
        put(16'h0345, 8'h22, 8'h00, 8'h00);
        put(16'h0003, 8'h31, 8'h23, 8'h00);
        put(16'h0123, 8'h32, 8'h00, 8'h00);
        put(16'h0005, 8'h80, 8'h09, 8'h00);
        put(16'h0010, 8'h60, 8'h05, 8'h00);
        put(16'h0012, 8'h02, 8'h02, 8'h00);
        put(16'h0200, 8'h73, 8'h00, 8'h00);
        put(16'h0500 + {8'h00, ACC}, 8'h12, 8'h04, 8'h00);
        put(16'h0400, 8'hd5, 8'h30, 8'hf0);
        put(16'h0403, 8'hb4, 8'hff, 8'h02);
        put(16'h0406, 8'h12, 8'h07, 8'h00);
        put(16'h0408, 8'h22, 8'h00, 8'h00);
        put(back_addr, 8'h90, 8'h12, 8'h34);
        put(back_addr + 16'h3, 8'h24, 8'h00, 8'h00);
        q = '{16'h0803, 16'h0900, 16'h0805, 16'h0900,
              {8'h08, back_addr[7:0]}, {8'h09, back_addr[15:8]}, 16'h3000};
        repeat (4) @(negedge CLK_SYS);
        RST = 0;
        // The probe call's own fetch passes back_addr too: wait for the
        // queue to drain so that only the final return counts
        for (int i = 0; i < 300 && (q.size() != 0 || PM_ADDR !== back_addr);
             i++) @(negedge CLK_SYS);
        chk(PM_ADDR, back_addr);
        chk({8'h00, SP}, 16'h0007);
        chk({15'h0, PROGRAM_STATUS_WORD[7]}, 16'h1);
        chk(16'(irq_seen), 16'h1);
        chk(16'(q.size()), 16'h0);
        // Pointer load then one add run within ten cycles
        repeat (10) @(negedge CLK_SYS);
        chk(16'(dp_seen), 16'h1);
        chk({8'h00, PROGRAM_STATUS_WORD}, {8'h00, ALU_CY, ALU_AC, 3'h0, ALU_OV, 2'h0});
        SFR_WADDR = PSW_ADDR;
        SFR_WDATA = 8'h85;
        SFR_WE = 1;
        @(negedge CLK_SYS) SFR_WE = 0;
        chk({8'h00, PROGRAM_STATUS_WORD}, 16'h0085);
        BIT_WADDR = 8'hd7;
        BIT_WE = 1;
        @(negedge CLK_SYS) BIT_WE = 0;
        chk({8'h00, PROGRAM_STATUS_WORD}, 16'h0005);
        close_out;
    end
endmodule
